// ---- hw/rmsc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmsc_device
#(
   parameter int LOCK_CYCLES = rmsc_pkg::LOCK_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // link to the controller
   rmsc_if.dev link,
   // decoded mode and circuit enables
   output rmsc_pkg::rmsc_mode_type mode,
   output logic osc1_en,
   output logic osc2_en,
   output logic rx_down_en,
   output logic tx_down_en,
   output logic wideband_en,
   output logic conv_en,
   output logic comp_en,
   output logic cal_tone_en,
   // latched control words and converter value
   output logic [12:0] word_a,
   output logic [12:0] word_b,
   output logic [12:0] word_c,
   output logic [12:0] word_d,
   output logic [12:0] word_e,
   output logic [7:0] conv_value
);
   import rmsc_pkg::*;

   typedef struct packed
   {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [PIN_W-1:0] f;
      logic [WORD_W-1:0] shreg;
      logic [12:0] wa;
      logic [12:0] wb;
      logic [12:0] wc;
      logic [12:0] wd;
      logic [12:0] we;
      logic [7:0] conv;
      rmsc_mode_type mode;
      logic [LOCK_CNT_W-1:0] lock_cnt;
      logic locked;
      logic lock_out;
      logic osc1;
      logic osc2;
      logic rxd;
      logic txd;
      logic wbd;
      logic cnv;
      logic cmp;
      logic cal;
   } rmsc_dev_state_type;

   rmsc_dev_state_type r_r;
   rmsc_dev_state_type r_nxt;

   logic [PIN_W-1:0] pins;
   logic [PIN_W-1:0] rise;
   logic [12:0] dfield;
   logic [2:0] afield;
   rmsc_mode_type pmode;
   logic pb;
   logic osc_on;

   assign pins = {link.receive_select, link.transmit_select, link.oscillator_enable_line,
                  link.converter_latch_strobe_n, link.word_strobe_n, link.serial_data,
                  link.serial_clk};

   always_comb
   begin
      r_nxt = r_r;
      // three-stage sampling; a level counts once stages two and three agree
      r_nxt.s1 = pins;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      r_nxt.f = (r_r.s2 & r_r.s3) | (r_r.f & (r_r.s2 ^ r_r.s3));
      rise = r_nxt.f & ~r_r.f;
      dfield = r_r.shreg[WORD_W-1:ADDR_W];
      afield = r_r.shreg[ADDR_W-1:0];

      // bits shift in while either strobe is low, oldest falls out the top
      if (rise[P_SCLK] && (!r_r.f[P_WSTB] || !r_r.f[P_CSTB]))
      begin
         r_nxt.shreg = {r_r.shreg[WORD_W-2:0], r_r.f[P_SDATA]};
      end

      // word strobe works in every mode, including sleep
      if (rise[P_WSTB])
      begin
         case (afield)
            ADDR_A: r_nxt.wa = dfield;
            ADDR_B: r_nxt.wb = dfield;
            ADDR_C: r_nxt.wc = dfield;
            ADDR_D: r_nxt.wd = dfield;
            ADDR_E:
            begin
               r_nxt.we = dfield;
               r_nxt.conv = dfield[CONV_LSB+CONV_W-1:CONV_LSB];
            end
            default: r_nxt.wa = r_r.wa;
         endcase
      end
      else if (rise[P_CSTB] && r_r.wb[B_DCE])
      begin
         // address field is not looked at for this strobe
         r_nxt.conv = dfield[CONV_LSB+CONV_W-1:CONV_LSB];
         r_nxt.we = dfield;
      end

      // parallel decode; unlisted combinations fall back to sleep
      case ({r_r.f[P_RS], r_r.f[P_TS], r_r.f[P_LOE]})
         3'h6: pmode = MODE_STANDBY;
         3'h2: pmode = MODE_RECEIVE;
         3'h4: pmode = MODE_TRANSMIT;
         default: pmode = MODE_SLEEP;
      endcase
      // serial mode bits win over the lines; transmit has priority
      if (r_r.wb[B_TX])
      begin
         r_nxt.mode = MODE_TRANSMIT;
      end
      else if (r_r.wb[B_RX])
      begin
         r_nxt.mode = MODE_RECEIVE;
      end
      else
      begin
         r_nxt.mode = pmode;
      end

      // the reference bit gates every radio circuit
      pb = r_r.wa[A_PB];
      osc_on = (r_r.mode != MODE_SLEEP) && pb;
      r_nxt.osc1 = osc_on && r_r.wa[A_VC1] && r_r.wa[A_PLL1] && r_r.wa[A_CP1];
      r_nxt.osc2 = osc_on && r_r.wa[A_VC2] && r_r.wa[A_PLL2] && r_r.wa[A_CP2];
      r_nxt.rxd = pb && (r_r.mode == MODE_RECEIVE);
      r_nxt.txd = pb && (r_r.mode == MODE_TRANSMIT);
      r_nxt.wbd = pb && (r_r.mode == MODE_TRANSMIT);
      r_nxt.cnv = osc_on && r_r.wb[B_DAC];
      r_nxt.cmp = pb && r_r.wb[B_COM] &&
                  ((r_r.mode == MODE_STANDBY) || (r_r.mode == MODE_RECEIVE));
      r_nxt.cal = pb && r_r.wb[B_CAL] && (r_r.mode == MODE_STANDBY);

      // lock is a fixed settling time after the oscillators come on
      if (!(r_r.osc1 || r_r.osc2))
      begin
         r_nxt.lock_cnt = '0;
         r_nxt.locked = 1'b0;
      end
      else if (r_r.lock_cnt == LOCK_CNT_W'(LOCK_CYCLES))
      begin
         r_nxt.locked = 1'b1;
      end
      else
      begin
         r_nxt.lock_cnt = r_r.lock_cnt + 1'b1;
      end
      // both select bits clear disable the indicator, which then reads high
      if (!r_r.wa[A_LD1] && !r_r.wa[A_LD2])
      begin
         r_nxt.lock_out = 1'b1;
      end
      else
      begin
         r_nxt.lock_out = r_r.locked;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r_r <= '0;
         // stages start at the idle pin levels, so no false clock edge follows reset
         r_r.s1 <= PINS_IDLE;
         r_r.s2 <= PINS_IDLE;
         r_r.s3 <= PINS_IDLE;
         r_r.f <= PINS_IDLE;
         r_r.wa <= DEF_A;
         r_r.wb <= DEF_B;
         r_r.wc <= DEF_C;
         r_r.wd <= DEF_D;
         r_r.we <= DEF_E;
         r_r.conv <= DEF_CONV;
         r_r.mode <= MODE_SLEEP;
         r_r.lock_out <= 1'b0;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign link.lock_indicator = r_r.lock_out;
   assign mode = r_r.mode;
   assign osc1_en = r_r.osc1;
   assign osc2_en = r_r.osc2;
   assign rx_down_en = r_r.rxd;
   assign tx_down_en = r_r.txd;
   assign wideband_en = r_r.wbd;
   assign conv_en = r_r.cnv;
   assign comp_en = r_r.cmp;
   assign cal_tone_en = r_r.cal;
   assign word_a = r_r.wa;
   assign word_b = r_r.wb;
   assign word_c = r_r.wc;
   assign word_d = r_r.wd;
   assign word_e = r_r.we;
   assign conv_value = r_r.conv;
endmodule
`default_nettype wire

// ---- hw/rmsc_pkg.sv ----
package rmsc_pkg;
   // serial word layout
   localparam int WORD_W = 16;
   localparam int DATA_W = 13;
   localparam int ADDR_W = 3;
   localparam int CONV_W = 8;
   localparam int CONV_LSB = 1;
   // address codes
   localparam logic [2:0] ADDR_TEST = 3'h0;
   localparam logic [2:0] ADDR_A = 3'h1;
   localparam logic [2:0] ADDR_B = 3'h2;
   localparam logic [2:0] ADDR_C = 3'h3;
   localparam logic [2:0] ADDR_D = 3'h4;
   localparam logic [2:0] ADDR_E = 3'h5;
   // power-up values of the data fields, first bit sent in bit 12
   localparam logic [12:0] DEF_A = 13'h1ffe;
   localparam logic [12:0] DEF_B = 13'h02fe;
   localparam logic [12:0] DEF_C = 13'h1b28;
   localparam logic [12:0] DEF_D = 13'h10c2;
   localparam logic [12:0] DEF_E = 13'h0000;
   localparam logic [7:0] DEF_CONV = 8'h00;
   // field positions inside the 13-bit data field (b0 sits at 12)
   localparam int A_VC1 = 12;
   localparam int A_VC2 = 11;
   localparam int A_PLL1 = 10;
   localparam int A_PLL2 = 9;
   localparam int A_CP1 = 8;
   localparam int A_CP2 = 7;
   localparam int A_LD1 = 4;
   localparam int A_LD2 = 3;
   localparam int A_PB = 1;
   localparam int B_TX = 12;
   localparam int B_RX = 11;
   localparam int B_DAC = 9;
   localparam int B_DCE = 8;
   localparam int B_COM = 7;
   localparam int B_CAL = 2;
   // synchronised pin vector positions in the device
   localparam int PIN_W = 7;
   localparam int P_SCLK = 0;
   localparam int P_SDATA = 1;
   localparam int P_WSTB = 2;
   localparam int P_CSTB = 3;
   localparam int P_LOE = 4;
   localparam int P_TS = 5;
   localparam int P_RS = 6;
   // idle levels: mode lines high (sleep), strobes high, clock and data low
   localparam logic [PIN_W-1:0] PINS_IDLE = 7'h7c;
   // timing
   localparam int CLK_MHZ = 50;
   localparam int CLK_PERIOD_NS = 20;
   localparam int LOCK_TIME_US = 150;
   localparam int LOCK_CYC = LOCK_TIME_US * CLK_MHZ;
   localparam int LOCK_CNT_W = 16;
   localparam int SCLK_HALF_NS = 80;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 8;
   // controller registers, byte addresses
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_MASK = 4'hc;
   localparam int CMD_SEL = 16;
   localparam int EV_W = 2;
   localparam int EV_DONE = 0;
   localparam int EV_REFUSED = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_LOCK = 3;
   localparam int M_LOE = 0;
   localparam int M_TS = 1;
   localparam int M_RS = 2;
   localparam logic [2:0] MODE_RST = 3'h7;
   localparam logic [EV_W-1:0] EV_RST = 2'h0;

   typedef enum logic [1:0]
   {
      MODE_SLEEP = 2'b00,
      MODE_STANDBY = 2'b01,
      MODE_RECEIVE = 2'b10,
      MODE_TRANSMIT = 2'b11
   } rmsc_mode_type;

   typedef enum logic [2:0]
   {
      H_IDLE = 3'b000,
      H_LEAD = 3'b001,
      H_LOW = 3'b010,
      H_HIGH = 3'b011,
      H_TAIL = 3'b100,
      H_END = 3'b101
   } rmsc_hstate_type;
endpackage

// ---- hw/rmsc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rmsc_if;
   logic serial_clk;
   logic serial_data;
   logic word_strobe_n;
   logic converter_latch_strobe_n;
   logic receive_select;
   logic transmit_select;
   logic oscillator_enable_line;
   logic lock_indicator;

   modport dev
   (
      input serial_clk,
      input serial_data,
      input word_strobe_n,
      input converter_latch_strobe_n,
      input receive_select,
      input transmit_select,
      input oscillator_enable_line,
      output lock_indicator
   );

   modport ctl
   (
      output serial_clk,
      output serial_data,
      output word_strobe_n,
      output converter_latch_strobe_n,
      output receive_select,
      output transmit_select,
      output oscillator_enable_line,
      input lock_indicator
   );
endinterface
`default_nettype wire

// ---- hw/rmsc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmsc_host
#(
   parameter int SCLK_HALF_CYCLES = rmsc_pkg::SCLK_HALF_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // interrupt
   output logic irq,
   // link to the device
   rmsc_if.ctl link
);
   import rmsc_pkg::*;

   typedef struct packed
   {
      logic wait_r;
      logic [31:0] rdata;
      logic [2:0] mode;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic irq;
      rmsc_hstate_type state;
      logic [TICK_W-1:0] tick_cnt;
      logic [3:0] bit_cnt;
      logic [WORD_W-1:0] word;
      logic sel;
      logic sclk;
      logic sdata;
      logic wstb_n;
      logic cstb_n;
      logic [2:0] lk;
      logic lk_f;
   } rmsc_host_state_type;

   rmsc_host_state_type r_r;
   rmsc_host_state_type r_nxt;

   logic tick;
   logic cmd_busy;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   logic [31:0] rmux;

   always_comb
   begin
      r_nxt = r_r;
      ev_set = '0;
      ev_clr = '0;
      tick = (r_r.tick_cnt == TICK_W'(SCLK_HALF_CYCLES - 1));
      cmd_busy = write && (address == REG_CMD) && (r_r.state != H_IDLE);

      // lock indicator comes from outside: three stages, agreement filter
      r_nxt.lk = {r_r.lk[1:0], link.lock_indicator};
      if (r_r.lk[1] == r_r.lk[2])
      begin
         r_nxt.lk_f = r_r.lk[2];
      end

      case (address)
         REG_MODE: rmux = {29'h0, r_r.mode};
         REG_STATUS: rmux = {28'h0, r_r.lk_f, r_r.state != H_IDLE, r_r.status};
         REG_MASK: rmux = {30'h0, r_r.mask};
         default: rmux = 32'h0;
      endcase

      // one wait cycle per access; a command stalls while a word is going out
      if ((read || write) && r_r.wait_r)
      begin
         if (!cmd_busy)
         begin
            r_nxt.wait_r = 1'b0;
            r_nxt.rdata = rmux;
         end
      end
      else if ((read || write) && !r_r.wait_r)
      begin
         r_nxt.wait_r = 1'b1;
         if (write)
         begin
            case (address)
               REG_MODE: r_nxt.mode = writedata[2:0];
               REG_STATUS: ev_clr = writedata[EV_W-1:0];
               REG_MASK: r_nxt.mask = writedata[EV_W-1:0];
               REG_CMD:
               begin
                  if (writedata[ADDR_W-1:0] == ADDR_TEST && !writedata[CMD_SEL])
                  begin
                     ev_set[EV_REFUSED] = 1'b1;
                  end
                  else
                  begin
                     r_nxt.word = writedata[WORD_W-1:0];
                     r_nxt.sel = writedata[CMD_SEL];
                     r_nxt.state = H_LEAD;
                     r_nxt.tick_cnt = '0;
                     r_nxt.bit_cnt = 4'h0;
                     r_nxt.sdata = writedata[WORD_W-1];
                     // only one strobe ever goes low
                     r_nxt.wstb_n = writedata[CMD_SEL];
                     r_nxt.cstb_n = !writedata[CMD_SEL];
                  end
               end
               default: r_nxt.wait_r = 1'b1;
            endcase
         end
      end
      else
      begin
         r_nxt.wait_r = 1'b1;
      end

      if (r_r.state != H_IDLE)
      begin
         r_nxt.tick_cnt = tick ? '0 : r_r.tick_cnt + 1'b1;
      end
      if (tick)
      begin
         case (r_r.state)
            H_LEAD: r_nxt.state = H_LOW;
            H_LOW:
            begin
               r_nxt.sclk = 1'b1;
               r_nxt.state = H_HIGH;
            end
            H_HIGH:
            begin
               // data moves on the falling edge, far from the sampling edge
               r_nxt.sclk = 1'b0;
               r_nxt.word = {r_r.word[WORD_W-2:0], 1'b0};
               r_nxt.sdata = r_r.word[WORD_W-2];
               r_nxt.bit_cnt = r_r.bit_cnt + 1'b1;
               r_nxt.state = (r_r.bit_cnt == 4'hf) ? H_TAIL : H_LOW;
            end
            H_TAIL:
            begin
               r_nxt.wstb_n = 1'b1;
               r_nxt.cstb_n = 1'b1;
               r_nxt.state = H_END;
            end
            H_END:
            begin
               ev_set[EV_DONE] = 1'b1;
               r_nxt.state = H_IDLE;
            end
            default: r_nxt.state = H_IDLE;
         endcase
      end

      // a new event beats a simultaneous clear
      r_nxt.status = (r_r.status & ~ev_clr) | ev_set;
      r_nxt.irq = |(r_nxt.status & r_nxt.mask);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r_r <= '0;
         r_r.wait_r <= 1'b1;
         r_r.mode <= MODE_RST;
         r_r.status <= EV_RST;
         r_r.mask <= EV_RST;
         r_r.state <= H_IDLE;
         r_r.wstb_n <= 1'b1;
         r_r.cstb_n <= 1'b1;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign readdata = r_r.rdata;
   assign waitrequest = r_r.wait_r;
   assign irq = r_r.irq;
   assign link.serial_clk = r_r.sclk;
   assign link.serial_data = r_r.sdata;
   assign link.word_strobe_n = r_r.wstb_n;
   assign link.converter_latch_strobe_n = r_r.cstb_n;
   assign link.receive_select = r_r.mode[M_RS];
   assign link.transmit_select = r_r.mode[M_TS];
   assign link.oscillator_enable_line = r_r.mode[M_LOE];
endmodule
`default_nettype wire

// ---- verification/rmsc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmsc_props
#(
   parameter int LOCK_CYCLES = rmsc_pkg::LOCK_CYC,
   parameter int SCLK_HALF_CYCLES = rmsc_pkg::SCLK_HALF_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // link wires
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic word_strobe_n,
   input wire logic converter_latch_strobe_n,
   input wire logic receive_select,
   input wire logic transmit_select,
   input wire logic oscillator_enable_line,
   input wire logic lock_indicator
);
   logic sclk_q_r;
   logic [7:0] hi_r;
   logic [7:0] lo_r;
   logic [4:0] bits_r;
   logic [15:0] on_r;
   logic frame;
   logic asleep;
   assign frame = !word_strobe_n || !converter_latch_strobe_n;
   assign asleep = receive_select && transmit_select && oscillator_enable_line;
   // low-time and on-time counters saturate so a long idle link never wraps into a false width
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclk_q_r <= 1'b0;
         hi_r <= 8'h00;
         lo_r <= 8'h00;
         bits_r <= 5'h00;
         on_r <= 16'h0000;
      end
      else
      begin
         sclk_q_r <= serial_clk;
         hi_r <= serial_clk ? hi_r + 8'h01 : 8'h00;
         lo_r <= serial_clk ? 8'h00 : lo_r + {7'h00, lo_r != 8'hff};
         bits_r <= frame ? bits_r + {4'h0, serial_clk && !sclk_q_r} : 5'h00;
         on_r <= asleep ? 16'h0000 : on_r + {15'h0000, on_r != 16'hffff};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   a_one_strobe: assert property (word_strobe_n || converter_latch_strobe_n)
      else $error("both strobes low at once");
   a_clk_in_frame: assert property (!frame |-> !serial_clk)
      else $error("serial clock high outside a frame");
   a_data_steady: assert property ($rose(serial_clk) |-> $stable(serial_data))
      else $error("serial data moved at clock rise");
   a_high_width: assert property ($fell(serial_clk) |-> hi_r == SCLK_HALF_CYCLES)
      else $error("serial clock high time wrong");
   a_low_width: assert property ($rose(serial_clk) |-> lo_r >= SCLK_HALF_CYCLES)
      else $error("serial clock low time short");
   a_sixteen_bits: assert property (($rose(word_strobe_n) || $rose(converter_latch_strobe_n))
      |-> bits_r == 5'h10 && !serial_clk)
      else $error("frame did not carry sixteen bits");
   a_lock_delay: assert property ($rose(lock_indicator) |-> on_r >= LOCK_CYCLES)
      else $error("lock flagged too early");
   a_sleep_unlock: assert property (asleep [*8] |-> ##4 !lock_indicator)
      else $error("lock still flagged in sleep");
   c_word: cover property ($rose(word_strobe_n));
   c_conv: cover property ($rose(converter_latch_strobe_n));
   c_lock: cover property ($rose(lock_indicator));
endmodule
`default_nettype wire

// ---- verification/test_rmsc.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rmsc;
   import rmsc_pkg::*;
   localparam int LOCK_T = 20;
   localparam int HALF_T = 4;
   localparam logic [2:0] LINES [4] = '{3'h6, 3'h2, 3'h4, 3'h7};
   localparam rmsc_mode_type MODES [4] = '{MODE_STANDBY, MODE_RECEIVE, MODE_TRANSMIT, MODE_SLEEP};
   localparam logic [7:0] ENS [4] = '{8'he3, 8'h73, 8'h6e, 8'h00};
   localparam logic [12:0] DATS [7] = '{13'h1ffa, 13'h03fe, 13'h0a5b, 13'h1234, 13'h0ab4,
      13'h1555, 13'h0aaa};
   localparam logic [12:0] DEFS [5] = '{DEF_A, DEF_B, DEF_C, DEF_D, DEF_E};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq;
   rmsc_mode_type mode;
   wire logic [7:0] en;
   wire logic [4:0][12:0] words;
   logic [7:0] conv;
   logic [31:0] rd;
   int miscompares = 0;
   int tests_run = 0;
   rmsc_if link ();
   always #10 clk = ~clk;
   rmsc_host #(.SCLK_HALF_CYCLES(HALF_T)) i_rmsc_host (.clk(clk), .arst_n(arst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .link(link));
   rmsc_device #(.LOCK_CYCLES(LOCK_T)) i_rmsc_device (.clk(clk), .arst_n(arst_n), .link(link),
      .mode(mode), .osc1_en(en[6]), .osc2_en(en[5]), .rx_down_en(en[4]), .tx_down_en(en[3]),
      .wideband_en(en[2]), .conv_en(en[1]), .comp_en(en[0]), .cal_tone_en(en[7]),
      .word_a(words[0]), .word_b(words[1]), .word_c(words[2]), .word_d(words[3]),
      .word_e(words[4]), .conv_value(conv));
   rmsc_props #(.LOCK_CYCLES(LOCK_T), .SCLK_HALF_CYCLES(HALF_T)) i_rmsc_props (.clk(clk),
      .arst_n(arst_n), .serial_clk(link.serial_clk), .serial_data(link.serial_data),
      .word_strobe_n(link.word_strobe_n),
      .converter_latch_strobe_n(link.converter_latch_strobe_n),
      .receive_select(link.receive_select), .transmit_select(link.transmit_select),
      .oscillator_enable_line(link.oscillator_enable_line),
      .lock_indicator(link.lock_indicator));

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic timeout(input string what);
      $display("[ERR] %s expected answer seen timeout", what);
      miscompares++;
      give_verdict();
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] r);
      int n;
      @(posedge clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= wd;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 400);
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 400)
         timeout("waitrequest");
   endtask

   task automatic send_word(input logic cstb, input logic [12:0] d, input logic [2:0] a);
      logic [31:0] r;
      int n;
      bus(1'b1, REG_CMD, {15'h0000, cstb, d, a}, r);
      n = 0;
      r = 32'h0;
      while (r[EV_DONE] !== 1'b1 && n < 100)
      begin
         bus(1'b0, REG_STATUS, 32'h0, r);
         n++;
      end
      if (n >= 100)
         timeout("done");
      bus(1'b1, REG_STATUS, 32'h1, r);
      // words and enables settle a few cycles after the latch edge
      repeat (8) @(posedge clk);
   endtask

   task automatic wait_mode(input rmsc_mode_type m);
      int n;
      n = 0;
      while (mode !== m && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      check("mode", 32'(m), 32'(mode));
      repeat (3) @(posedge clk);
   endtask

   task automatic t_defaults();
      for (int i = 0; i < 5; i++)
         check("word", 32'(DEFS[i]), 32'(words[i]));
      check("conv", 32'(DEF_CONV), 32'(conv));
      bus(1'b0, REG_MODE, 32'h0, rd);
      check("mode reg", 32'(MODE_RST), rd);
      bus(1'b0, 4'h2, 32'h0, rd);
      check("unmapped", 32'h0, rd);
   endtask

   task automatic t_modes();
      int n;
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, REG_MODE, 32'(LINES[i]), rd);
         wait_mode(MODES[i]);
         check("enables", 32'(ENS[i]), 32'(en));
         if (i == 0)
         begin
            check("early lock", 32'h0, 32'(link.lock_indicator));
            n = 0;
            while (link.lock_indicator !== 1'b1 && n < LOCK_T + 10)
            begin
               @(posedge clk);
               n++;
            end
            if (n >= LOCK_T + 10)
               timeout("lock");
            // the host filters the indicator through three stages before status shows it
            repeat (4) @(posedge clk);
            bus(1'b0, REG_STATUS, 32'h0, rd);
            check("lock bit", 32'h1, 32'(rd[ST_LOCK]));
         end
      end
   endtask

   task automatic t_words();
      send_word(1'b1, 13'h01fe, ADDR_E);
      check("conv ignored", 32'(DEF_CONV), 32'(conv));
      for (int a = 1; a < 8; a++)
         send_word(1'b0, DATS[a-1], 3'(a));
      for (int i = 0; i < 5; i++)
         check("word", 32'(DATS[i]), 32'(words[i]));
      check("conv", 32'(DATS[4][8:1]), 32'(conv));
      send_word(1'b1, 13'h01fe, ADDR_A);
      check("conv strobe", 32'hff, 32'(conv));
      check("word_a kept", 32'(DATS[0]), 32'(words[0]));
   endtask

   task automatic t_override();
      bus(1'b1, REG_MODE, 32'h6, rd);
      wait_mode(MODE_STANDBY);
      send_word(1'b0, 13'h13fe, ADDR_B);
      check("forced mode", 32'(MODE_TRANSMIT), 32'(mode));
      check("tx path", 32'h1, 32'(en[3]));
      // receive override, transmit bit clear
      send_word(1'b0, 13'h0bfe, ADDR_B);
      check("forced rx", 32'(MODE_RECEIVE), 32'(mode));
      check("rx path", 32'h1, 32'(en[4]));
      send_word(1'b0, 13'h0ffa, ADDR_A);
      check("osc1 off", 32'h0, 32'(en[6]));
      check("osc2 on", 32'h1, 32'(en[5]));
      send_word(1'b0, 13'h1ffa, ADDR_A);
      send_word(1'b0, 13'h03fe, ADDR_B);
      bus(1'b1, REG_MODE, 32'h7, rd);
      wait_mode(MODE_SLEEP);
   endtask

   task automatic t_irq();
      bus(1'b1, REG_MASK, 32'h3, rd);
      bus(1'b1, REG_STATUS, 32'h3, rd);
      bus(1'b1, REG_CMD, 32'h0000_1238, rd);
      bus(1'b0, REG_STATUS, 32'h0, rd);
      check("refused", 32'h2, 32'(rd[1:0]));
      check("irq on", 32'h1, 32'(irq));
      bus(1'b1, REG_MASK, 32'h1, rd);
      bus(1'b0, REG_MASK, 32'h0, rd);
      check("mask", 32'h1, rd);
      check("irq masked", 32'h0, 32'(irq));
      bus(1'b1, REG_MASK, 32'h3, rd);
      bus(1'b1, REG_STATUS, 32'h2, rd);
      bus(1'b0, REG_STATUS, 32'h0, rd);
      check("cleared", 32'h0, 32'(rd[1:0]));
      check("irq off", 32'h0, 32'(irq));
      check("word_a kept", 32'h1ffa, 32'(words[0]));
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      t_defaults();
      t_modes();
      t_words();
      t_override();
      t_irq();
      give_verdict();
   end
endmodule
`default_nettype wire
